// *** design/irq_flags.sv ***
`timescale 1ns/1ns
module irq_flags
   import irq_flags_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic interval_tick_i,
   input wire logic serial_done_i,
   input wire logic counter_match_i,
   input wire logic pulse_gen_match_i,
   input wire logic clock_timer_i,
   input wire logic filtered_ext_pin_i,
   input wire logic second_ext_pin_i,
   input wire logic third_ext_pin_i,
   input wire logic both_edge_ext_pin_i,
   input wire logic [7:0] key_inputs_i,
   input wire logic standby_i,
   input wire logic accept_i,
   input wire logic [2:0] accept_vector_i,
   output logic [5:0] vectored_request_o,
   output logic [2:0] top_vector_o,
   output logic wake_o
);
   logic [8:0] request_flag;
   logic [8:0] enable_flag;
   logic [3:0] ext_filtered_ext_pin_edge_mode;
   logic [3:0] ext_second_ext_pin_edge_mode;
   logic [3:0] ext_third_ext_pin_key_mode;
   logic master_int_enable;
   logic [5:0] div_cnt;
   logic [11:0] pin_now;
   logic [11:0] pin_old;
   logic filt_now;
   logic filt_old;
   logic key_low_old;
   bus_state_t bus_state;

   // Edge test for a mode field
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic now,
                                     input logic old);
      logic rise;
      logic fall;
      rise = now & ~old;
      fall = ~now & old;
      case (sel)
         E_RISE: edge_hit = rise;
         E_FALL: edge_hit = fall;
         E_BOTH: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   // Key group chosen by mode bits 1:0
   function automatic logic [7:0] key_mask(input logic [1:0] sel);
      case (sel)
         2'h1: key_mask = 8'hF0;
         2'h2: key_mask = 8'hFC;
         2'h3: key_mask = 8'hFF;
         default: key_mask = 8'h00;
      endcase
   endfunction

   // Map vector number to flag bits cleared on acceptance
   function automatic logic [8:0] vec_flags(input logic [2:0] v);
      case (v)
         3'h1: vec_flags = 9'h003;
         3'h2: vec_flags = 9'h004;
         3'h3: vec_flags = 9'h008;
         3'h4: vec_flags = 9'h010;
         3'h5: vec_flags = 9'h020;
         3'h6: vec_flags = 9'h040;
         default: vec_flags = 9'h000;
      endcase
   endfunction

   pin_sync #(.W(12)) u_sync
   (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .pins_i({key_inputs_i, both_edge_ext_pin_i, third_ext_pin_i,
               second_ext_pin_i, filtered_ext_pin_i}),
      .pins_o(pin_now)
   );

   // Sampling ticks for the first pin; none in standby
   wire div_tick = (div_cnt == DIV_LAST);
   wire samp_tick = ~standby_i &
      (ext_filtered_ext_pin_edge_mode[M_SCLK] ? div_tick : 1'b1);

   noise_filter u_filt
   (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .tick_i(samp_tick),
      .pin_i(pin_now[0]),
      .level_o(filt_now)
   );

   // Pin edge events
   wire ev_ext0 = ~standby_i &
      edge_hit(ext_filtered_ext_pin_edge_mode[1:0], filt_now, filt_old);
   wire ev_ext1 = edge_hit(ext_second_ext_pin_edge_mode[1:0],
      pin_now[1], pin_old[1]);
   wire ev_both = pin_now[3] ^ pin_old[3];
   wire [7:0] kmask = key_mask(ext_third_ext_pin_key_mode[1:0]);
   wire key_mode = |kmask;
   wire key_low = |(~pin_now[11:4] & kmask);
   wire ev_key = key_mode ? (key_low & ~key_low_old)
      : (pin_now[2] & ~pin_old[2]);

   // Hardware set vector
   wire [8:0] hw_set = {clock_timer_i, ev_key, pulse_gen_match_i,
      counter_match_i, serial_done_i, ev_ext1, ev_ext0, ev_both,
      interval_tick_i};

   // Bus decode
   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire [7:0] adr = paddr[7:0];
   wire hit_req = (adr == A_REQ);
   wire hit_rset = (adr == A_REQ_SET);
   wire hit_rclr = (adr == A_REQ_CLR);
   wire hit_en = (adr == A_EN);
   wire hit_eset = (adr == A_EN_SET);
   wire hit_eclr = (adr == A_EN_CLR);
   wire hit_m0 = (adr == A_MODE0);
   wire hit_m1 = (adr == A_MODE1);
   wire hit_m2 = (adr == A_MODE2);
   wire hit_ctrl = (adr == A_CTRL);
   wire hit_stat = (adr == A_STAT);
   wire mapped = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'h0) &
      (hit_req | hit_rset | hit_rclr | hit_en | hit_eset | hit_eclr |
       hit_m0 | hit_m1 | hit_m2 | hit_ctrl | hit_stat);
   wire wr_ok = wr & mapped;
   wire [8:0] wbits = pwdata[8:0];

   // Acceptance clear; the shared vector clears only a lone source
   wire [8:0] pend = request_flag & enable_flag;
   wire share_one = pend[F_BT] ^ pend[F_BOTH];
   wire [8:0] acc_raw = accept_i ? vec_flags(accept_vector_i) : 9'h000;
   wire [8:0] acc_clr = (accept_vector_i == 3'h1)
      ? (share_one ? (acc_raw & pend) : 9'h000)
      : acc_raw;

   // Software view of the request flags
   wire [8:0] sw_req =
      (wr_ok & hit_req) ? wbits :
      (wr_ok & hit_rset) ? (request_flag | wbits) :
      (wr_ok & hit_rclr) ? (request_flag & ~wbits) :
      request_flag;
   wire [8:0] next_request_flag = (sw_req & ~acc_clr) | hw_set;

   wire [8:0] next_enable_flag =
      (wr_ok & hit_en) ? wbits :
      (wr_ok & hit_eset) ? (enable_flag | wbits) :
      (wr_ok & hit_eclr) ? (enable_flag & ~wbits) :
      enable_flag;

   // Vectored requests from the next flag state
   wire [8:0] next_pend = next_request_flag & next_enable_flag;
   wire [5:0] next_vrq = {6{master_int_enable}} & {
      next_pend[F_PG], next_pend[F_CNT], next_pend[F_SER],
      next_pend[F_EXT1], next_pend[F_EXT0],
      next_pend[F_BT] | next_pend[F_BOTH]};
   wire [2:0] next_top =
      next_vrq[0] ? 3'h1 :
      next_vrq[1] ? 3'h2 :
      next_vrq[2] ? 3'h3 :
      next_vrq[3] ? 3'h4 :
      next_vrq[4] ? 3'h5 :
      next_vrq[5] ? 3'h6 : 3'h0;
   wire next_wake = |next_pend;

   // Read data mux
   wire [31:0] rd_val =
      (hit_req | hit_rset | hit_rclr) ? {23'h000000, request_flag} :
      (hit_en | hit_eset | hit_eclr) ? {23'h000000, enable_flag} :
      hit_m0 ? {28'h0000000, ext_filtered_ext_pin_edge_mode} :
      hit_m1 ? {28'h0000000, ext_second_ext_pin_edge_mode} :
      hit_m2 ? {28'h0000000, ext_third_ext_pin_key_mode} :
      hit_ctrl ? {31'h00000000, master_int_enable} :
      hit_stat ? {19'h00000, filt_now, top_vector_o, wake_o,
                  vectored_request_o, 2'h0} :
      32'h00000000;
   wire next_pready = psel & penable & ~pready;
   wire req_sel = psel & penable & ~pready;

   // Flags
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         request_flag <= FLAGS_RST;
         enable_flag <= FLAGS_RST;
      end
      else if (ce_i)
      begin
         request_flag <= next_request_flag;
         enable_flag <= next_enable_flag;
      end
   end

   // Mode registers and master enable
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         ext_filtered_ext_pin_edge_mode <= MODE_RST;
         ext_second_ext_pin_edge_mode <= MODE_RST;
         ext_third_ext_pin_key_mode <= MODE_RST;
         master_int_enable <= 1'b0;
      end
      else if (ce_i && wr_ok)
      begin
         if (hit_m0)
            ext_filtered_ext_pin_edge_mode <= pwdata[3:0];
         else if (hit_m1)
            ext_second_ext_pin_edge_mode <= pwdata[3:0];
         else if (hit_m2)
            ext_third_ext_pin_key_mode <= pwdata[3:0];
         else if (hit_ctrl)
            master_int_enable <= pwdata[0];
      end
   end

   // Edge history and sample divider
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         pin_old <= '0;
         filt_old <= 1'b0;
         key_low_old <= 1'b0;
         div_cnt <= 6'h00;
      end
      else if (ce_i)
      begin
         pin_old <= pin_now;
         key_low_old <= key_low;
         div_cnt <= div_tick ? 6'h00 : div_cnt + 6'h01;
         if (~standby_i)
            filt_old <= filt_now;
      end
   end

   // Request outputs
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         vectored_request_o <= 6'h00;
         top_vector_o <= 3'h0;
         wake_o <= 1'b0;
      end
      else if (ce_i)
      begin
         vectored_request_o <= next_vrq;
         top_vector_o <= next_top;
         wake_o <= next_wake;
      end
   end

   // APB slave: one wait cycle, answer registered
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         bus_state <= BUS_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (ce_i)
      begin
         bus_state <= next_pready ? BUS_ACK : BUS_IDLE;
         pready <= next_pready;
         pslverr <= req_sel & ~mapped;
         if (req_sel)
            prdata <= (mapped & ~pwrite) ? rd_val : 32'h00000000;
      end
   end
endmodule // irq_flags

// *** design/irq_flags_pkg.sv ***
// Operation
// - Nine request flags, each with its own enable flag.
// - Source event sets its flag; CPU acceptance clears it automatically, except the key and clock flags.
// - Timer and both-edge pin share vector one; acceptance clears differently.
// - Vectored request raised while one of the first seven flags and its enable are both one.
// - Any of the nine flags with its enable set also releases standby, whatever the master enable.
// - Flags reachable by single-bit set or clear and by word writes.
// - A flag written to one by software requests like a hardware event.
// - Reset clears every request and enable flag.
// - Internal flags set by timer, serial, counter, pulse and clock events.
// - Both-edge pin sets its flag on every rising and falling edge.
// - First and second pins use the edge chosen in their mode register.
// - First pin filter rejects pulses no longer than one sample period.
// - Mode bit 3 picks CPU clock or divided clock for sampling.
// - Mode bits 0 and 1 pick the first pin's detected edge.
// - Reset clears first and second mode registers, selecting rising edge.
// - First pin edge detection stops while in standby.
// - Third flag set by rising edge of third pin in pin mode.
// - Key mode selects key group; falling edge of group sets third flag.
// - Any selected key held low blocks further key falling edges.
// - Reset clears third mode register, selecting third pin rising edge.
// - Master enable zero blocks every vectored interrupt.
// - Simultaneous requests resolved by fixed vector priority.
package irq_flags_pkg;
   localparam int NUM_FLAGS = 9;
   localparam int NUM_VEC = 6;
   // Flag bit positions
   localparam int F_BT = 0;
   localparam int F_BOTH = 1;
   localparam int F_EXT0 = 2;
   localparam int F_EXT1 = 3;
   localparam int F_SER = 4;
   localparam int F_CNT = 5;
   localparam int F_PG = 6;
   localparam int F_KEY = 7;
   localparam int F_CLK = 8;
   // Register byte offsets
   localparam logic [7:0] A_REQ = 8'h00;
   localparam logic [7:0] A_REQ_SET = 8'h04;
   localparam logic [7:0] A_REQ_CLR = 8'h08;
   localparam logic [7:0] A_EN = 8'h0C;
   localparam logic [7:0] A_EN_SET = 8'h10;
   localparam logic [7:0] A_EN_CLR = 8'h14;
   localparam logic [7:0] A_MODE0 = 8'h18;
   localparam logic [7:0] A_MODE1 = 8'h1C;
   localparam logic [7:0] A_MODE2 = 8'h20;
   localparam logic [7:0] A_CTRL = 8'h24;
   localparam logic [7:0] A_STAT = 8'h28;
   // Reset values
   localparam logic [8:0] FLAGS_RST = 9'h000;
   localparam logic [3:0] MODE_RST = 4'h0;
   // Mode fields
   localparam int M_SCLK = 3;
   localparam logic [1:0] E_RISE = 2'h0;
   localparam logic [1:0] E_FALL = 2'h1;
   localparam logic [1:0] E_BOTH = 2'h2;
   localparam logic [1:0] E_NONE = 2'h3;
   // Divided sample clock: one tick per 64 cycles
   localparam int DIV_CYC = 64;
   localparam logic [5:0] DIV_LAST = 6'(DIV_CYC - 1);
   localparam int KEYS = 8;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } bus_state_t;
endpackage

// *** design/noise_filter.sv ***
`timescale 1ns/1ns
module noise_filter
   import irq_flags_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic tick_i,
   input wire logic pin_i,
   output logic level_o
);
   logic last;

   // A level is taken only after two equal samples in a row
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         last <= 1'b0;
         level_o <= 1'b0;
      end
      else if (ce_i && tick_i)
      begin
         last <= pin_i;
         if (last == pin_i)
            level_o <= pin_i;
      end
   end
endmodule // noise_filter

// *** design/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync
   import irq_flags_pkg::*;
#(
   parameter int W = 12
)(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] pins_i,
   output logic [W-1:0] pins_o
);
   logic [W-1:0] meta;

   // Two-stage synchroniser; only the second stage is read
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         meta <= '0;
         pins_o <= '0;
      end
      else if (ce_i)
      begin
         meta <= pins_i;
         pins_o <= meta;
      end
   end
endmodule // pin_sync

// *** verif/cpu_pin_model.sv ***
`timescale 1ns/1ns
module cpu_pin_model (
   input wire logic clock_i,
   input wire logic take_i,
   input wire logic [2:0] top_vector_i,
   output logic accept_o,
   output logic [2:0] accept_vector_o
);
   initial accept_o = 1'b0;
   initial accept_vector_o = 3'h0;
   // One-cycle acceptance pulses, at most every other cycle while take is high; otherwise the vector lines wander
   always @(posedge clock_i)
      if (take_i && !accept_o && top_vector_i != 3'h0)
      begin
         accept_o <= 1'b1;
         accept_vector_o <= top_vector_i;
      end
      else
      begin
         accept_o <= 1'b0;
         accept_vector_o <= ~accept_vector_o;
      end
endmodule // cpu_pin_model

// *** verif/irq_flags_assertions.sv ***
`timescale 1ns/1ns
module irq_flags_assertions
   import irq_flags_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_done_i,
   input wire logic accept_i,
   input wire logic [2:0] accept_vector_i,
   input wire logic [5:0] vectored_request_o,
   input wire logic [2:0] top_vector_o,
   input wire logic wake_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   a_reset_clear: assert property (disable iff (1'b0)
      sys_rst_i |=> vectored_request_o == 6'h0 && !wake_o)
      else $error("outputs not cleared by reset");
   a_ready_wait: assert property (
      psel && !penable |=> !pready ##1 pready)
      else $error("bus answer not after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_align: assert property (
      pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   a_err_data: assert property (
      pslverr |-> pready && prdata == 32'h0)
      else $error("refused access carries data");
   a_vec_wake: assert property (
      vectored_request_o != 6'h0 |-> wake_o)
      else $error("request without wake");
   a_top_first: assert property (
      vectored_request_o[0] |-> top_vector_o == 3'h1)
      else $error("vector one not first");
   a_flag_hold: assert property (
      vectored_request_o[3] && !accept_i && !$past(accept_i)
      && !(psel && pwrite) && !$past(psel && pwrite)
      |=> vectored_request_o[3])
      else $error("serial request dropped alone");
   a_accept_clear: assert property (
      accept_i && accept_vector_i == 3'h4 && !serial_done_i
      && vectored_request_o[3] |-> ##[1:2] !vectored_request_o[3])
      else $error("accepted request not cleared");
   cover property (accept_i && vectored_request_o[3]);
   cover property (pslverr);
   cover property (top_vector_o == 3'h1);
endmodule // irq_flags_assertions

bind irq_flags irq_flags_assertions irq_flags_assertions_i (
   .clock_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .serial_done_i, .accept_i, .accept_vector_i,
   .vectored_request_o, .top_vector_o, .wake_o
);

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
   import irq_flags_pkg::*;
   typedef struct {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic x;
   } row_t;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] ev = 5'h0;
   logic [3:0] pin = 4'h0;
   logic [7:0] keys = 8'hFF;
   logic standby = 1'b0;
   logic take = 1'b0;
   logic accept;
   logic [2:0] acc_vec;
   logic [5:0] vreq;
   logic [2:0] top;
   logic wake;
   logic [31:0] rd;
   logic er;
   int bad_count = 0;
   int checks = 0;
   row_t rows [17] = '{
      '{'0, A_REQ, '0, '0, '0}, '{'0, A_EN, '0, '0, '0},
      '{'0, A_MODE0, '0, '0, '0}, '{'0, A_MODE1, '0, '0, '0},
      '{'0, A_MODE2, '0, '0, '0}, '{'0, A_CTRL, '0, '0, '0},
      '{'1, A_EN, 32'h1FF, '0, '0}, '{'0, A_EN, '0, 32'h1FF, '0},
      '{'1, A_REQ_SET, 32'h10, '0, '0}, '{'1, A_CTRL, 32'h1, '0, '0},
      '{'0, A_STAT, '0, 32'h920, '0}, '{'1, A_REQ_CLR, 32'h10, '0, '0},
      '{'0, A_REQ, '0, '0, '0}, '{'1, A_MODE1, '1, '0, '0},
      '{'0, A_MODE1, '0, 32'hF, '0}, '{'0, 8'h2C, '0, '0, '1},
      '{'1, 8'h2D, 32'h1, '0, '1}
   };

   irq_flags irq_flags_i (
      .clock_i, .sys_rst_i, .ce_i(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr,
      .interval_tick_i(ev[0]), .serial_done_i(ev[1]),
      .counter_match_i(ev[2]), .pulse_gen_match_i(ev[3]),
      .clock_timer_i(ev[4]), .filtered_ext_pin_i(pin[0]),
      .second_ext_pin_i(pin[1]), .third_ext_pin_i(pin[2]),
      .both_edge_ext_pin_i(pin[3]), .key_inputs_i(keys),
      .standby_i(standby), .accept_i(accept),
      .accept_vector_i(acc_vec), .vectored_request_o(vreq),
      .top_vector_o(top), .wake_o(wake)
   );
   cpu_pin_model cpu_pin_model_i (
      .clock_i, .take_i(take), .top_vector_i(top),
      .accept_o(accept), .accept_vector_o(acc_vec)
   );

   always #4 clock_i = ~clock_i;

   task cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      // Look at the answer mid-cycle; it takes effect at the next edge
      @(negedge clock_i);
      while (pready !== 1'b1)
      begin
         @(negedge clock_i);
         n++;
      end
      rd = prdata;
      er = pslverr;
      @(posedge clock_i);
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(2);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task clr;
      apb(1'b1, A_REQ_CLR, 32'h1FF);
   endtask
   task acc;
      take <= 1'b1;
      cyc(6);
      take <= 1'b0;
      @(posedge clock_i);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      cyc(20000);
      bad_count++;
      complete_run();
   end

   initial
   begin
      cyc(8);
      sys_rst_i <= 1'b0;
      cyc(2);
      chk({26'h0, vreq}, 32'h0);
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk(rd, rows[i].e);
         chk({31'h0, er}, {31'h0, rows[i].x});
      end
      apb(1'b1, A_MODE1, 32'h0);
      $display("table done");
      ev <= 5'h1F;
      @(posedge clock_i);
      ev <= 5'h0;
      cyc(2);
      rchk(A_REQ, 32'h171);
      clr();
      ev <= 5'h2;
      clr();
      ev <= 5'h0;
      rchk(A_REQ, 32'h10);
      acc();
      rchk(A_REQ, 32'h0);
      apb(1'b1, A_REQ_SET, 32'h3);
      acc();
      rchk(A_REQ, 32'h3);
      apb(1'b1, A_REQ_CLR, 32'h2);
      acc();
      rchk(A_REQ, 32'h0);
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_REQ_SET, 32'h8);
      chk({26'h0, vreq}, 32'h0);
      chk({31'h0, wake}, 32'h1);
      apb(1'b1, A_CTRL, 32'h1);
      chk({26'h0, vreq}, 32'h4);
      $display("events done");
      for (int p = 0; p < 2; p++)
         for (int m = 0; m < 4; m++)
         begin
            apb(1'b1, p ? A_MODE1 : A_MODE0, 32'(m));
            clr();
            pin[p] <= 1'b1;
            cyc(8);
            rchk(A_REQ, 32'(m == 0 || m == 2) << (p + 2));
            clr();
            pin[p] <= 1'b0;
            cyc(8);
            rchk(A_REQ, 32'(m == 1 || m == 2) << (p + 2));
         end
      apb(1'b1, A_MODE0, 32'h0);
      pin[0] <= 1'b1;
      @(posedge clock_i);
      pin[0] <= 1'b0;
      cyc(8);
      rchk(A_REQ, 32'h0);
      apb(1'b1, A_MODE0, 32'h8);
      cyc(130);
      clr();
      pin[0] <= 1'b1;
      cyc(3);
      pin[0] <= 1'b0;
      cyc(140);
      rchk(A_REQ, 32'h0);
      pin[0] <= 1'b1;
      cyc(200);
      rchk(A_REQ, 32'h4);
      pin[0] <= 1'b0;
      cyc(200);
      apb(1'b1, A_MODE0, 32'h0);
      clr();
      standby <= 1'b1;
      pin[0] <= 1'b1;
      cyc(10);
      rchk(A_REQ, 32'h0);
      pin[0] <= 1'b0;
      cyc(10);
      standby <= 1'b0;
      $display("edge modes done");
      for (int k = 2; k < 4; k++)
      begin
         pin[k] <= 1'b1;
         cyc(8);
         rchk(A_REQ, k == 3 ? 32'h2 : 32'h80);
         clr();
         pin[k] <= 1'b0;
         cyc(8);
         rchk(A_REQ, k == 3 ? 32'h2 : 32'h0);
         clr();
      end
      apb(1'b1, A_MODE2, 32'h1);
      clr();
      keys <= 8'hDF;
      cyc(8);
      rchk(A_REQ, 32'h80);
      clr();
      keys <= 8'h9E;
      cyc(8);
      rchk(A_REQ, 32'h0);
      keys <= 8'hFF;
      apb(1'b1, A_MODE2, 32'h3);
      clr();
      keys <= 8'hFE;
      cyc(8);
      rchk(A_REQ, 32'h80);
      $display("pins and keys done");
      sys_rst_i <= 1'b1;
      cyc(8);
      sys_rst_i <= 1'b0;
      cyc(2);
      rchk(A_EN, 32'h0);
      rchk(A_MODE2, 32'h0);
      $display("second reset done");
      complete_run();
   end
endmodule // tb
